/* File: core/bzt_top.sv */
// Behaviour
// - Pin select 00 port pins, 01 tone on first pin, 11 pair, 10 reserved
// - Tone equals timebase clock over two to the power of field plus two
// - In pair mode first pin data bit gates both; low forces both low
// - Second pin data bit never affects the complementary tone
// - Single mode: first pin as output tones when data high, else low
// - A pin set as input is always an input, whatever the selection
// - Second pin of the pair carries the inverse of the first pin tone
// - Timebase from external crystal, internal RC, or system clock over four
`default_nettype none
module bzt_top #(
  parameter int CNT_W = bzt_pkg::TONE_CNT_W
) (
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_resetn,
  input  wire logic [bzt_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [bzt_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  output logic      [bzt_pkg::DATA_W-1:0] o_rdata,
  input  wire logic                      i_xtal_clk,
  input  wire logic                      i_rc_clk,
  input  wire logic                      i_pa6,
  input  wire logic                      i_pa7,
  output bzt_pkg::bzt_pin_t              o_pa6,
  output bzt_pkg::bzt_pin_t              o_pa7
);
  import bzt_pkg::*;

  logic [7:0] tone_control_reg;
  logic [7:0] port_a_direction_reg;
  logic [7:0] port_a_data_reg;
  logic [1:0] tb_src_reg;
  logic [7:0] rdata_reg;

  // Synchronisers for pins and slow clocks
  logic       pa6_s1_reg, pa6_s2_reg;
  logic       pa7_s1_reg, pa7_s2_reg;
  logic       xt_s1_reg, xt_s2_reg, xt_prev_reg;
  logic       rc_s1_reg, rc_s2_reg, rc_prev_reg;
  logic [1:0] pre_cnt_reg;
  logic       tb_tick;
  logic       tone;
  logic       tone_reg;

  logic [1:0] pin_select;
  logic [2:0] tone_divide_sel;
  logic       dir6, dir7, dat6, dat7;
  logic       tone_on_pin6, pair_mode;
  bzt_pin_t   pa6_next, pa7_next;
  bzt_pin_t   pa6_reg, pa7_reg;

  assign pin_select      = tone_control_reg[SEL_HI_POS:SEL_LO_POS];
  assign tone_divide_sel = tone_control_reg[DIVSEL_MSB:DIVSEL_LSB];
  assign dir6            = port_a_direction_reg[PIN6_POS];
  assign dir7            = port_a_direction_reg[PIN7_POS];
  assign dat6            = port_a_data_reg[PIN6_POS];
  assign dat7            = port_a_data_reg[PIN7_POS];

  // Register writes; all eight control bits kept, upper three unused here
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      tone_control_reg <= RST_TONE_CTRL;
    end else if (i_wr && i_addr == ADDR_TONE_CTRL) begin
      tone_control_reg <= i_wdata;
    end
  end

  // Port direction: one means input
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      port_a_direction_reg <= RST_PA_DIR;
    end else if (i_wr && i_addr == ADDR_PA_DIR) begin
      port_a_direction_reg <= i_wdata;
    end
  end

  // Port data latch
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      port_a_data_reg <= RST_PA_DATA;
    end else if (i_wr && i_addr == ADDR_PA_DATA) begin
      port_a_data_reg <= i_wdata;
    end
  end

  // Timebase source selection
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      tb_src_reg <= RST_TB_SRC;
    end else if (i_wr && i_addr == ADDR_TB_SRC) begin
      tb_src_reg <= i_wdata[1:0];
    end
  end

  // Read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      rdata_reg <= READ_ZERO;
    end else if (i_rd) begin
      if (i_addr == ADDR_TONE_CTRL) begin
        rdata_reg <= tone_control_reg;
      end else if (i_addr == ADDR_PA_DIR) begin
        rdata_reg <= port_a_direction_reg;
      end else if (i_addr == ADDR_PA_DATA) begin
        rdata_reg <= port_a_data_reg;
      end else if (i_addr == ADDR_TB_SRC) begin
        rdata_reg <= {6'h00, tb_src_reg};
      end else if (i_addr == ADDR_STATUS) begin
        rdata_reg <= {5'h00, tone_reg, pa7_s2_reg, pa6_s2_reg};
      end else begin
        rdata_reg <= READ_ZERO;
      end
    end else begin
      rdata_reg <= READ_ZERO;
    end
  end

  assign o_rdata = rdata_reg;

  // Pin input synchronisers; only the second stage is read
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      pa6_s1_reg <= 1'b0;
      pa6_s2_reg <= 1'b0;
      pa7_s1_reg <= 1'b0;
      pa7_s2_reg <= 1'b0;
    end else begin
      pa6_s1_reg <= i_pa6;
      pa6_s2_reg <= pa6_s1_reg;
      pa7_s1_reg <= i_pa7;
      pa7_s2_reg <= pa7_s1_reg;
    end
  end

  // Slow oscillators sampled as data; edge seen after the second stage
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      xt_s1_reg   <= 1'b0;
      xt_s2_reg   <= 1'b0;
      xt_prev_reg <= 1'b0;
      rc_s1_reg   <= 1'b0;
      rc_s2_reg   <= 1'b0;
      rc_prev_reg <= 1'b0;
    end else begin
      xt_s1_reg   <= i_xtal_clk;
      xt_s2_reg   <= xt_s1_reg;
      xt_prev_reg <= xt_s2_reg;
      rc_s1_reg   <= i_rc_clk;
      rc_s2_reg   <= rc_s1_reg;
      rc_prev_reg <= rc_s2_reg;
    end
  end

  // System clock prescaler, free running
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      pre_cnt_reg <= 2'h0;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 2'h1;
    end
  end

  // Timebase tick: one system cycle per timebase rising edge
  always_comb begin
    if (tb_src_reg == TB_XTAL) begin
      tb_tick = xt_s2_reg && !xt_prev_reg;
    end else if (tb_src_reg == TB_RC) begin
      tb_tick = rc_s2_reg && !rc_prev_reg;
    end else begin
      tb_tick = (pre_cnt_reg == PRESCALE_LAST);
    end
  end

  bzt_divider #(
    .CNT_W (CNT_W)
  ) u_div (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_tick    (tb_tick),
    .i_sel     (tone_divide_sel),
    .o_tone    (tone)
  );

  // Reserved select code behaves as plain port pins
  assign tone_on_pin6 = (pin_select == PSEL_SINGLE) ||
                        (pin_select == PSEL_PAIR);
  assign pair_mode    = (pin_select == PSEL_PAIR);

  // Pin drive: direction bit wins, then tone gating by first data bit
  always_comb begin
    pa6_next.oe = !dir6;
    pa7_next.oe = !dir7;
    if (tone_on_pin6) begin
      pa6_next.out = dat6 & tone;
    end else begin
      pa6_next.out = dat6;
    end
    if (pair_mode) begin
      pa7_next.out = dat6 & !tone;
    end else begin
      pa7_next.out = dat7;
    end
  end

  // Registered pin drive keeps outputs glitch free
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      pa6_reg  <= '0;
      pa7_reg  <= '0;
      tone_reg <= 1'b0;
    end else begin
      pa6_reg  <= pa6_next;
      pa7_reg  <= pa7_next;
      tone_reg <= tone;
    end
  end

  assign o_pa6 = pa6_reg;
  assign o_pa7 = pa7_reg;

endmodule
`default_nettype wire

/* File: core/bzt_pkg.sv */
`default_nettype none
package bzt_pkg;

  // Register port geometry
  localparam int          ADDR_W = 3;
  localparam int          DATA_W = 8;

  // Register offsets, one per address
  localparam logic [2:0]  ADDR_TONE_CTRL = 3'h0;
  localparam logic [2:0]  ADDR_PA_DIR    = 3'h1;
  localparam logic [2:0]  ADDR_PA_DATA   = 3'h2;
  localparam logic [2:0]  ADDR_TB_SRC    = 3'h3;
  localparam logic [2:0]  ADDR_STATUS    = 3'h4;

  // Reset values
  localparam logic [7:0]  RST_TONE_CTRL  = 8'h00;
  localparam logic [7:0]  RST_PA_DIR     = 8'hff;
  localparam logic [7:0]  RST_PA_DATA    = 8'h00;
  localparam logic [1:0]  RST_TB_SRC     = 2'h2;
  localparam logic [7:0]  READ_ZERO      = 8'h00;

  // Field positions inside tone_control_reg
  localparam int          SEL_HI_POS     = 4;
  localparam int          SEL_LO_POS     = 3;
  localparam int          DIVSEL_MSB     = 2;
  localparam int          DIVSEL_LSB     = 0;

  // Bit positions of the two shared port pins
  localparam int          PIN6_POS       = 6;
  localparam int          PIN7_POS       = 7;

  // Status register layout
  localparam int          ST_PIN6_POS    = 0;
  localparam int          ST_PIN7_POS    = 1;
  localparam int          ST_TONE_POS    = 2;

  // Pin selection codes
  localparam logic [1:0]  PSEL_PORT      = 2'h0;
  localparam logic [1:0]  PSEL_SINGLE    = 2'h1;
  localparam logic [1:0]  PSEL_RESERVED  = 2'h2;
  localparam logic [1:0]  PSEL_PAIR      = 2'h3;

  // Timebase source codes
  localparam logic [1:0]  TB_XTAL        = 2'h0;
  localparam logic [1:0]  TB_RC          = 2'h1;
  localparam logic [1:0]  TB_SYSDIV      = 2'h2;

  // System clock prescale for the timebase, and tone counter width
  localparam int          SYS_PRESCALE   = 4;
  localparam logic [1:0]  PRESCALE_LAST  = 2'(SYS_PRESCALE - 1);
  localparam int          TONE_CNT_W     = 9;
  localparam logic [3:0]  DIV_EXP_BASE   = 4'h2;

  // Drive of one shared pin
  typedef struct packed {
    logic out;
    logic oe;
  } bzt_pin_t;

  // Counter mask covering one full tone period
  function automatic logic [TONE_CNT_W-1:0] bzt_period_mask(
    input logic [2:0] sel
  );
    logic [3:0] expo;
    expo = {1'b0, sel} + DIV_EXP_BASE;
    return TONE_CNT_W'((32'h1 << expo) - 32'h1);
  endfunction

endpackage
`default_nettype wire

/* File: core/bzt_divider.sv */
`default_nettype none
module bzt_divider #(
  parameter int CNT_W = bzt_pkg::TONE_CNT_W
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_tick,
  input  wire logic [2:0] i_sel,
  output logic            o_tone
);
  import bzt_pkg::*;

  logic [CNT_W-1:0] cnt_reg;
  logic [2:0]       sel_act_reg;
  logic [CNT_W-1:0] mask;
  logic             period_end;
  logic [3:0]       half_pos;

  assign mask       = CNT_W'(bzt_period_mask(sel_act_reg));
  assign period_end = i_tick && ((cnt_reg & mask) == mask);
  assign half_pos   = {1'b0, sel_act_reg} + 4'h1;

  // Restart at each period end so high and low halves match
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      cnt_reg <= '0;
    end else if (period_end) begin
      cnt_reg <= '0;
    end else if (i_tick) begin
      cnt_reg <= cnt_reg + CNT_W'(1);
    end
  end

  // New ratio only at a period boundary, so no runt pulse
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      sel_act_reg <= 3'h0;
    end else if (period_end) begin
      sel_act_reg <= i_sel;
    end
  end

  // Upper half of the period is high: 50 percent duty
  assign o_tone = cnt_reg[half_pos];

endmodule
`default_nettype wire

/* File: testbench/bzt_chk.sv */
`default_nettype none
module bzt_chk (
  input wire logic              i_sys_clk,
  input wire logic              i_resetn,
  input wire logic [2:0]        i_addr,
  input wire logic [7:0]        i_wdata,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire logic [7:0]        o_rdata,
  input wire bzt_pkg::bzt_pin_t o_pa6,
  input wire bzt_pkg::bzt_pin_t o_pa7
);
  timeunit 1ns;
  timeprecision 1ns;
  import bzt_pkg::*;
  logic [7:0] ctl_reg, dir_reg, dat_reg;
  logic       live_reg;
  // Shadow of software writes; pins answer one cycle behind it
  always_ff @(posedge i_sys_clk) begin
    live_reg <= i_resetn;
    if (!i_resetn) begin
      ctl_reg <= RST_TONE_CTRL;
      dir_reg <= RST_PA_DIR;
      dat_reg <= RST_PA_DATA;
    end else if (i_wr) begin
      if (i_addr == ADDR_TONE_CTRL) ctl_reg <= i_wdata;
      if (i_addr == ADDR_PA_DIR) dir_reg <= i_wdata;
      if (i_addr == ADDR_PA_DATA) dat_reg <= i_wdata;
    end
  end
  wire logic [1:0] sel = ctl_reg[4:3];
  // First edge after reset is skipped: the shadow is still settling
  default clocking dc @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn || !live_reg);
  a_read_idle: assert property (!$past(i_rd) |-> o_rdata == READ_ZERO)
    else $error("read data outside its slot");
  a_ctrl_readback: assert property (
    $past(i_rd && i_addr == ADDR_TONE_CTRL) |-> o_rdata == $past(ctl_reg))
    else $error("control readback wrong");
  a_input6_float: assert property ($past(dir_reg[6]) |-> !o_pa6.oe)
    else $error("first pin driven while input");
  a_input7_float: assert property ($past(dir_reg[7]) |-> !o_pa7.oe)
    else $error("second pin driven while input");
  a_port6_data: assert property ($past(!sel[0] && !dir_reg[6])
    |-> o_pa6 == {$past(dat_reg[6]), 1'b1}) else $error("first port pin");
  a_port7_data: assert property (
    $past(sel != PSEL_PAIR && !dir_reg[7])
    |-> o_pa7 == {$past(dat_reg[7]), 1'b1}) else $error("second port pin");
  a_tone_gate_off: assert property (
    $past(sel[0] && !dir_reg[6] && !dat_reg[6]) |-> o_pa6 == 2'b01)
    else $error("first tone pin not held low");
  a_pair_gate_off: assert property (
    $past(sel == PSEL_PAIR && !dir_reg[7] && !dat_reg[6])
    |-> o_pa7 == 2'b01) else $error("second tone pin not held low");
  a_pair_inverse: assert property (
    $past(sel == PSEL_PAIR && dir_reg[7:6] == 2'h0 && dat_reg[6])
    |-> o_pa6.out != o_pa7.out) else $error("pair not complementary");
endmodule
bind bzt_top bzt_chk bzt_chk_inst (
  .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_pa6(o_pa6), .o_pa7(o_pa7)
);
`default_nettype wire

/* File: testbench/bzt_piezo.sv */
`default_nettype none
module bzt_piezo (
  input  wire logic        i_sys_clk,
  input  wire logic        i_pin_a,
  input  wire logic        i_pin_b,
  output logic      [15:0] o_hi_len,
  output logic      [15:0] o_lo_len,
  output logic             o_diff
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] run_reg = 16'h0;
  logic        last_reg = 1'b0;
  // Passive load: times each high and low stretch on the first terminal
  always_ff @(posedge i_sys_clk) begin
    last_reg <= i_pin_a;
    if (i_pin_a != last_reg) begin
      run_reg <= 16'h1;
      if (last_reg) o_hi_len <= run_reg;
      else o_lo_len <= run_reg;
    end else begin
      run_reg <= run_reg + 16'h1;
    end
  end
  // High when the terminals oppose, as a differential drive needs
  assign o_diff = i_pin_a ^ i_pin_b;
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import bzt_pkg::*;
  logic       i_sys_clk = 1'b0, i_resetn = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h0, o_rdata, rd_val;
  logic       xtal = 1'b0, rc = 1'b0, ext6 = 1'b1, ext7 = 1'b0;
  logic       p6, p7, diff;
  bzt_pin_t   o_pa6, o_pa7;
  logic [15:0] hi_len, lo_len;
  int          fails = 0, checks = 0, cyc = 0;
  // Wire levels: device drive wins, else the outside world
  assign p6 = o_pa6.oe ? o_pa6.out : ext6;
  assign p7 = o_pa7.oe ? o_pa7.out : ext7;
  // Slow sources are whole multiples of the system period, off its rising edges
  initial forever #5 i_sys_clk = ~i_sys_clk;
  initial forever #60 xtal = ~xtal;
  initial forever #50 rc = ~rc;
  bzt_top bzt_top_inst (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_xtal_clk(xtal), .i_rc_clk(rc), .i_pa6(p6),
    .i_pa7(p7), .o_pa6(o_pa6), .o_pa7(o_pa7));
  bzt_piezo bzt_piezo_inst (.i_sys_clk(i_sys_clk), .i_pin_a(p6),
    .i_pin_b(p7), .o_hi_len(hi_len), .o_lo_len(lo_len), .o_diff(diff));
  // Bus cycles, one strobe cycle each
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 rd_val = o_rdata;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic chk_reg(input string n, input logic [7:0] e,
                         input logic [7:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  // Seen value first, expected second, as the number checks read best
  task automatic chk_num(input string n, input logic [15:0] g,
                         input logic [15:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] e,
                     input string n);
    rd(a);
    chk_reg(n, e, rd_val);
  endtask
  task automatic print_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard, well above the longest expected run
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      print_verdict();
    end
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    rdc(ADDR_TONE_CTRL, 8'h00, "ctrl reset");
    rdc(ADDR_PA_DIR, RST_PA_DIR, "dir reset");
    rdc(ADDR_PA_DATA, RST_PA_DATA, "data reset");
    rdc(ADDR_TB_SRC, {6'h00, RST_TB_SRC}, "tbsrc reset");
    rdc(3'h5, READ_ZERO, "unmapped");
    wr(ADDR_TONE_CTRL, 8'hff);
    rdc(ADDR_TONE_CTRL, 8'hff, "ctrl rw");
    rd(ADDR_STATUS);
    chk_reg("status in", 8'h01, rd_val & 8'h03);
    chk_num("oe inputs", 16'({o_pa6.oe, o_pa7.oe}), 16'h0);
    $display("test registers done");
    wr(ADDR_PA_DIR, 8'h00);
    wr(ADDR_PA_DATA, 8'h80);
    for (int s = 0; s < 3; s += 2) begin
      wr(ADDR_TONE_CTRL, 8'(s << 3));
      wt(3);
      chk_num("port pins", 16'({p6, p7}), 16'h1);
    end
    $display("test port done");
    wr(ADDR_TONE_CTRL, 8'h08);
    wt(3);
    chk_num("single off", 16'({p6, p7}), 16'h1);
    wr(ADDR_PA_DATA, 8'hc0);
    // Ratio 7 from the readback test holds until its 2048-cycle period ends
    wt(2200);
    chk_num("single hi", hi_len, 16'h8);
    chk_num("single pa7", 16'(p7), 16'h1);
    $display("test single done");
    for (int d = 0; d < 8; d++) begin
      wr(ADDR_TONE_CTRL, 8'h18 | 8'(d));
      wt(64 << d);
      chk_num("pair hi", hi_len, 16'(8 << d));
      chk_num("pair lo", lo_len, 16'(8 << d));
      chk_num("pair inv", 16'(diff), 16'h1);
    end
    $display("test pair done");
    wr(ADDR_PA_DATA, 8'h80);
    wt(3);
    chk_num("pair off", 16'({p6, p7}), 16'h0);
    wr(ADDR_PA_DATA, 8'hc0);
    ext7 <= 1'b1;
    wr(ADDR_PA_DIR, 8'h80);
    wt(3);
    chk_num("pa7 input", 16'({o_pa7.oe, p7}), 16'h1);
    rd(ADDR_STATUS);
    chk_reg("status pa7", 8'h02, rd_val & 8'h02);
    $display("test gate done");
    wr(ADDR_PA_DIR, 8'h00);
    wr(ADDR_TONE_CTRL, 8'h18);
    // Let the long ratio finish on the fast timebase before slowing it
    wt(2200);
    for (int s = 0; s < 2; s++) begin
      wr(ADDR_TB_SRC, 8'(s));
      wt(2200);
      chk_num("source hi", hi_len, s ? 16'h14 : 16'h18);
    end
    $display("test source done");
    print_verdict();
  end
endmodule
`default_nettype wire
